// ===== src/dssb_top.sv
// safe stop sequencing and two-channel safe brake control with apb registers
`timescale 1ns/1ps
module dssb_top import dssb_pkg::*; #(
  parameter int MON_CYCLES = MON_CYCLE_CLKS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // selection inputs
  input wire logic sel_ctrl_n,
  input wire logic sel_pwr_n,
  input wire logic tel_valid,
  input wire logic tel_sto_sel,
  // drive and brake side
  input wire logic brake_release_req,
  input wire logic brake_current_fb,
  input wire logic ctrl_heartbeat,
  output logic pulse_en_ctrl,
  output logic pulse_en_pwr,
  output logic quick_stop_ramp_command,
  output logic brake_high_switch,
  output logic brake_low_switch,
  output logic stop_notice_control_side,
  output logic stop_notice_power_side
);

  // ==========================================
  // state
  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic tel_phase;
    logic tel_sel;
    logic tel_eval;
    logic [2:0] tel_pipe;
    logic flt_c;
    logic flt_p;
    logic [7:0] fcnt_c;
    logic [7:0] fcnt_p;
    dssb_chan_type ch_c;
    dssb_chan_type ch_p;
    logic [7:0] xcnt;
    logic [2:0] fault;
    logic brake_open;
    logic [3:0] test_cnt;
    logic hb_prev;
    logic [7:0] wd_cnt;
    logic [15:0] dly_c;
    logic [15:0] dly_p;
    logic [15:0] filt;
    logic [15:0] tol;
    logic [15:0] en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pen_c;
    logic pen_p;
    logic qstop;
    logic brk_hs;
    logic brk_ls;
    logic note_c;
    logic note_p;
  } dssb_state_type;

  dssb_state_type s;
  dssb_state_type next_s;

  // ==========================================
  // helpers
  function automatic logic [8:0] dssb_filter(logic flt, logic [7:0] cnt, logic raw, logic [7:0] lim);
    logic [8:0] r;
    r = {flt, 8'h00};
    if (raw != flt) begin
      if (cnt >= lim) begin
        r = {raw, 8'h00};
      end else begin
        r = {flt, cnt + 8'h01};
      end
    end
    return r;
  endfunction

  function automatic dssb_chan_type dssb_chan_step(dssb_chan_type c, logic sel, logic trip,
                                                   logic [15:0] dly);
    dssb_chan_type n;
    n = c;
    case (c.st)
      CH_RUN: begin
        if (trip || (sel && dly == 16'h0000)) begin
          n.st = CH_STO;
        end else if (sel) begin
          n.st = CH_DELAY;
          n.tmr = dly;
          n.wd = 1'b0;
        end
      end
      CH_DELAY: begin
        n.tmr = c.tmr - 16'h0001;
        if (!sel) begin
          n.wd = 1'b1;
        end
        if (trip || c.tmr <= 16'h0001) begin
          n.st = CH_STO;
        end
      end
      CH_STO: begin
        if (!sel && !trip) begin
          n.st = CH_RUN;
          n.wd = 1'b0;
        end
      end
      default: begin
        n.st = CH_STO;
      end
    endcase
    return n;
  endfunction

  // ==========================================
  // combinational view
  logic access;
  logic hit;
  logic wr_en;
  logic sbc_act;
  logic mode_warn;
  logic sel_c;
  logic sel_p;
  logic trip;
  logic any_sto;
  logic next_any_sto;
  logic brake_want;
  logic [2:0] fault_set;
  logic [2:0] fault_clr;
  logic [8:0] fres_c;
  logic [8:0] fres_p;
  logic [31:0] rd_val;

  always_comb begin
    next_s = s;
    fault_set = 3'h0;
    fault_clr = 3'h0;
    rd_val = 32'h0000_0000;
    // filter results only mean something on a tick; zero keeps them from latching
    fres_c = 9'h000;
    fres_p = 9'h000;
    access = psel && penable;
    hit = (paddr == OFS_FAULT) || (paddr == OFS_DLY_C) || (paddr == OFS_DLY_P) ||
          (paddr == OFS_FILT) || (paddr == OFS_TOL) || (paddr == OFS_EN) || (paddr == OFS_STAT);
    wr_en = access && s.pready && pwrite && hit;
    // safe brake needs an equal nonzero monitor enable on both sides
    sbc_act = s.en[EN_BRK_C] && s.en[EN_BRK_P] && (s.en[EN_SAFE_C_LSB +: 4] == s.en[EN_SAFE_P_LSB +: 4]) &&
              (s.en[EN_SAFE_C_LSB +: 4] != 4'h0);
    mode_warn = (s.en[EN_MODE_LSB +: 2] == 2'b00) || (s.en[EN_MODE_LSB +: 2] == 2'b11);
    trip = s.fault != 3'h0;
    // active-low terminal, or a telegram selection, asks for the stop
    sel_c = s.flt_c || s.tel_pipe[2];
    sel_p = s.flt_p || s.tel_pipe[2];
    any_sto = (s.ch_c.st == CH_STO) || (s.ch_p.st == CH_STO);

    // monitoring cycle divider
    next_s.tick = 1'b0;
    if (s.tick_cnt == TICK_W'(MON_CYCLES - 1)) begin
      next_s.tick_cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + TICK_W'(1);
    end

    // telegram held until its scan slot, then delayed through the pipe
    if (tel_valid) begin
      next_s.tel_sel = tel_sto_sel;
    end
    next_s.hb_prev = ctrl_heartbeat;
    if (ctrl_heartbeat != s.hb_prev) begin
      next_s.wd_cnt = 8'h00;
    end

    if (s.tick) begin
      next_s.tel_phase = !s.tel_phase;
      if (s.tel_phase) begin
        next_s.tel_eval = s.tel_sel;
      end
      next_s.tel_pipe = {s.tel_pipe[1:0], s.tel_eval};

      // debounce per channel, low level selects
      fres_c = dssb_filter(s.flt_c, s.fcnt_c, !sel_ctrl_n, s.filt[7:0]);
      fres_p = dssb_filter(s.flt_p, s.fcnt_p, !sel_pwr_n, s.filt[15:8]);
      next_s.flt_c = fres_c[8];
      next_s.fcnt_c = fres_c[7:0];
      next_s.flt_p = fres_p[8];
      next_s.fcnt_p = fres_p[7:0];

      // both channels run their own sequence on every tick
      next_s.ch_c = dssb_chan_step(s.ch_c, sel_c, trip, s.dly_c);
      next_s.ch_p = dssb_chan_step(s.ch_p, sel_p, trip, s.dly_p);

      // cross-comparison of the two filtered selections
      if (s.flt_c != s.flt_p) begin
        next_s.xcnt = s.xcnt + 8'h01;
        if (s.xcnt >= s.tol[7:0] || s.xcnt >= s.tol[15:8]) begin
          fault_set[FLT_XCHECK] = 1'b1;
        end
      end else begin
        next_s.xcnt = 8'h00;
      end

      // control side silent too long: power side takes over
      if (ctrl_heartbeat == s.hb_prev) begin
        if (s.wd_cnt >= WD_TICKS) begin
          fault_set[FLT_WDOG] = 1'b1;
        end else begin
          next_s.wd_cnt = s.wd_cnt + 8'h01;
        end
      end

      // brake feedback only judged after a state change settles
      if (s.test_cnt != 4'h0) begin
        next_s.test_cnt = s.test_cnt - 4'h1;
        if (s.test_cnt == 4'h1 && brake_current_fb != s.brake_open) begin
          fault_set[FLT_BRAKE] = 1'b1;
        end
      end
    end

    next_any_sto = (next_s.ch_c.st == CH_STO) || (next_s.ch_p.st == CH_STO);

    // brake: mode setting never overrides the safe close
    brake_want = brake_release_req && !trip;
    if (sbc_act && next_any_sto) begin
      brake_want = 1'b0;
    end
    next_s.brake_open = brake_want;
    if (brake_want != s.brake_open || (sbc_act && next_any_sto && !any_sto)) begin
      next_s.test_cnt = BRAKE_TEST_TICKS;
    end
    // both switches drop together so one welded switch still cuts current
    next_s.brk_hs = brake_want;
    next_s.brk_ls = brake_want;

    // pulse paths are independent per channel
    next_s.pen_c = next_s.ch_c.st != CH_STO;
    next_s.pen_p = next_s.ch_p.st != CH_STO;
    next_s.qstop = next_s.ch_c.st == CH_DELAY;
    next_s.note_c = next_s.ch_c.st == CH_DELAY;
    next_s.note_p = next_s.ch_p.st == CH_DELAY;

    // apb: one wait state, data and error with pready
    case (paddr)
      OFS_FAULT: rd_val = {29'h0, s.fault};
      OFS_DLY_C: rd_val = {16'h0, s.dly_c};
      OFS_DLY_P: rd_val = {16'h0, s.dly_p};
      OFS_FILT: rd_val = {16'h0, s.filt};
      OFS_TOL: rd_val = {16'h0, s.tol};
      OFS_EN: rd_val = {16'h0, s.en};
      OFS_STAT: rd_val = {20'h0, sbc_act, mode_warn, s.brake_open, s.ch_p.wd, s.ch_c.wd, s.ch_p.st,
                          s.ch_c.st, s.flt_p, s.flt_c, s.qstop};
      default: rd_val = 32'h0000_0000;
    endcase
    next_s.pready = access && !s.pready;
    next_s.pslverr = access && !s.pready && !hit;
    next_s.prdata = (access && !s.pready && !pwrite) ? rd_val : 32'h0000_0000;
    if (wr_en) begin
      case (paddr)
        OFS_FAULT: fault_clr = pwdata[2:0];
        OFS_DLY_C: next_s.dly_c = pwdata[15:0];
        OFS_DLY_P: next_s.dly_p = pwdata[15:0];
        OFS_FILT: next_s.filt = pwdata[15:0];
        OFS_TOL: next_s.tol = pwdata[15:0];
        OFS_EN: next_s.en = pwdata[15:0];
        default: fault_clr = 3'h0;
      endcase
    end
    // a new fault beats a clear in the same cycle
    next_s.fault = (s.fault & ~fault_clr) | fault_set;
  end

  // ==========================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ch_c.st <= CH_STO;
      s.ch_p.st <= CH_STO;
      s.dly_c <= RST_DLY;
      s.dly_p <= RST_DLY;
      s.filt <= RST_FILT;
      s.tol <= RST_TOL;
      s.en <= RST_EN;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign pulse_en_ctrl = s.pen_c;
  assign pulse_en_pwr = s.pen_p;
  assign quick_stop_ramp_command = s.qstop;
  assign brake_high_switch = s.brk_hs;
  assign brake_low_switch = s.brk_ls;
  assign stop_notice_control_side = s.note_c;
  assign stop_notice_power_side = s.note_p;

  // ==========================================
  // checks
  default clocking dssb_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence dssb_sel_zero_s;
    s.tick && s.ch_c.st == CH_RUN && sel_c && s.dly_c == 16'h0000;
  endsequence

  sequence dssb_sel_delay_s;
    s.tick && s.ch_c.st == CH_RUN && sel_c && s.dly_c != 16'h0000 && !trip;
  endsequence

  sequence dssb_expiry_s;
    s.tick && s.ch_c.st == CH_DELAY && s.ch_c.tmr <= 16'h0001 && !trip;
  endsequence

  // brake close and its test are launched by the same edge that enters torque off
  sequence dssb_sbc_entry_s;
    sbc_act && !any_sto && next_any_sto;
  endsequence

  zero_delay_a: assert property (dssb_sel_zero_s |=> s.ch_c.st == CH_STO ##1 !pulse_en_ctrl)
    else $error("zero delay did not cut torque");
  delay_entry_a: assert property (dssb_sel_delay_s |=> s.ch_c.st == CH_DELAY ##1 quick_stop_ramp_command)
    else $error("timed stop not entered");
  timer_hold_a: assert property (s.tick && s.ch_c.st == CH_DELAY && s.ch_c.tmr > 16'h0001 && !trip
                                 |=> s.ch_c.st == CH_DELAY && s.ch_c.tmr == $past(s.ch_c.tmr) - 16'h0001)
    else $error("delay timer did not keep counting");
  expiry_sto_a: assert property (dssb_expiry_s |=> s.ch_c.st == CH_STO)
    else $error("expiry did not enter torque off");
  withdraw_leave_a: assert property (s.tick && s.ch_c.st == CH_STO && s.ch_c.wd && !sel_c && !trip
                                     |=> s.ch_c.st == CH_RUN)
    else $error("withdrawn stop did not leave torque off");
  ramp_one_chan_a: assert property (quick_stop_ramp_command |-> $past(s.ch_c.st) == CH_DELAY ||
                                    s.ch_c.st == CH_DELAY)
    else $error("ramp command without control channel delay");
  // the switches follow the next state, so torque off now means they were dropped last edge
  sbc_close_a: assert property (sbc_act && $past(sbc_act) && s.ch_p.st == CH_STO
                                |-> !brake_high_switch && !brake_low_switch)
    else $error("brake not closed on torque off");
  fault_safe_a: assert property (s.fault != 3'h0 |=> !brake_high_switch && !brake_low_switch)
    else $error("brake current on during fault");
  xcheck_fault_a: assert property (s.tick && s.flt_c != s.flt_p && s.xcnt >= s.tol[7:0]
                                   |=> s.fault[FLT_XCHECK])
    else $error("channel disagreement not faulted");
  brake_test_a: assert property ($changed(s.brake_open) |-> s.test_cnt == BRAKE_TEST_TICKS)
    else $error("brake change started no test");
  sbc_entry_test_a: assert property (dssb_sbc_entry_s
                                     |=> s.test_cnt == BRAKE_TEST_TICKS && !brake_low_switch)
    else $error("torque off entry did not close and test the brake");
  pwr_zero_delay_a: assert property (s.tick && s.ch_p.st == CH_RUN && sel_p && s.dly_p == 16'h0000
                                     |=> !pulse_en_pwr)
    else $error("power channel did not cut pulses");
  tel_slot_a: assert property (!(s.tick && s.tel_phase) |=> $stable(s.tel_eval))
    else $error("telegram evaluated outside its scan slot");
  filter_hold_a: assert property (s.tick && s.flt_c == sel_ctrl_n && s.fcnt_c < s.filt[7:0]
                                  |=> s.flt_c == $past(s.flt_c))
    else $error("selection passed the filter too early");

endmodule

// ===== src/dssb_pkg.sv
// constants, types and field layout for the drive safe stop and brake block
// ==========================================
// Operation
// - timed safe stop: quick-stop ramp, then torque off after delay
// - zero delay means immediate torque off, nonzero means timed stop
// - with nonzero delay a terminal never trips torque off directly
// - delay timer keeps running even if selection is withdrawn
// - withdrawn during delay: torque off at expiry, then leave at once
// - selection on both channels, ramp command from one channel only
// - per-channel debounce filter with its own filter time
// - torque off or monitor response also closes brake safely
// - safe brake acts two-channel whatever the brake mode; modes 0,3 flagged
// - each torque off with safe brake active closes brake at once and forces a brake test
// - brake wiring checked when the brake changes state or torque off is entered with safe brake active
// - safe brake inactive unless a monitor is enabled equally on both sides
// - power side watches control side and closes brake if it fails
// - fault on either side cuts brake current and forces safe state
// - functions run once per monitoring cycle, telegrams every two
// - terminal torque off within two to four cycles, brake four to eight
// - terminal timed stop starts braking within two to four cycles
// - telegram torque off after five cycles, brake four to ten
// - telegram timed stop: torque off five cycles plus the delay
// - timed stop state shown in status and per-side notices
// - torque off: each channel cuts pulses on its own path, brake closes
// - channels disagreeing beyond tolerance raise a stop fault
package dssb_pkg;

  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MON_CYCLE_US = 4000;
  localparam int MON_CYCLE_CLKS = MON_CYCLE_US * 1000 / CLK_PERIOD_NS;
  localparam int TICK_W = 24;
  localparam logic [3:0] BRAKE_TEST_TICKS = 4'h2;
  localparam logic [7:0] WD_TICKS = 8'h04;

  // ==========================================
  // register offsets
  localparam logic [7:0] OFS_FAULT = 8'h00;
  localparam logic [7:0] OFS_DLY_C = 8'h04;
  localparam logic [7:0] OFS_DLY_P = 8'h08;
  localparam logic [7:0] OFS_FILT = 8'h0c;
  localparam logic [7:0] OFS_TOL = 8'h10;
  localparam logic [7:0] OFS_EN = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;

  // ==========================================
  // reset values and fields
  localparam logic [15:0] RST_DLY = 16'h0000;
  localparam logic [15:0] RST_FILT = 16'h0000;
  localparam logic [15:0] RST_TOL = 16'h0404;
  localparam logic [15:0] RST_EN = 16'h0000;
  localparam int EN_SAFE_C_LSB = 0;
  localparam int EN_SAFE_P_LSB = 4;
  localparam int EN_BRK_C = 8;
  localparam int EN_BRK_P = 9;
  localparam int EN_MODE_LSB = 12;
  localparam int FLT_XCHECK = 0;
  localparam int FLT_BRAKE = 1;
  localparam int FLT_WDOG = 2;

  // ==========================================
  // channel sequence
  typedef enum logic [1:0] {
    CH_RUN = 2'b00,
    CH_DELAY = 2'b01,
    CH_STO = 2'b10
  } dssb_mode_type;

  typedef struct packed {
    dssb_mode_type st;
    logic [15:0] tmr;
    logic wd;
  } dssb_chan_type;

endpackage

// ===== tb/dssb_partner.sv
// far-side model: brake winding current sense and control-side life signal
`timescale 1ns/1ps
module dssb_partner #(
  parameter int MON_CYCLES = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // brake switches from the block
  input wire logic brake_high_switch,
  input wire logic brake_low_switch,
  // fault injection
  input wire logic hb_stop,
  input wire logic fb_stuck,
  // answers to the block
  output logic brake_current_fb,
  output logic ctrl_heartbeat
);
  // ====
  // model
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      ctrl_heartbeat <= 1'b0;
      brake_current_fb <= 1'b0;
    end else begin
      // current only with both switches on or with fb_stuck forcing it, no relay in the path
      brake_current_fb <= (brake_high_switch & brake_low_switch) | fb_stuck;
      cnt <= (cnt == MON_CYCLES - 1) ? 0 : cnt + 1;
      // toggles every tick, well inside the allowed four
      if (cnt == 0 && !hb_stop) begin
        ctrl_heartbeat <= ~ctrl_heartbeat;
      end
    end
  end
endmodule

// ===== tb/dssb_top_tb_top.sv
// self-checking bench for the safe stop and brake block
`timescale 1ns/1ps
module dssb_top_tb_top;
  import dssb_pkg::*;
  // ====
  // signals
  localparam int M = 10;
  localparam int D = 3;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sel_ctrl_n = 1'b1;
  logic sel_pwr_n = 1'b1;
  logic tel_valid = 1'b0;
  logic tel_sto_sel = 1'b0;
  logic brake_release_req = 1'b0;
  logic hb_stop = 1'b0;
  logic fb_stuck = 1'b0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, brake_current_fb, ctrl_heartbeat, pulse_en_ctrl, pulse_en_pwr;
  logic quick_stop_ramp_command, brake_high_switch, brake_low_switch;
  logic stop_notice_control_side, stop_notice_power_side;
  int fails = 0;
  int checks_done = 0;
  int n;
  wire [5:0] outs = {stop_notice_power_side, stop_notice_control_side, brake_low_switch,
    quick_stop_ramp_command, pulse_en_pwr, pulse_en_ctrl};
  always #12.5 pclk = ~pclk;
  dssb_top #(.MON_CYCLES(M)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sel_ctrl_n, .sel_pwr_n, .tel_valid, .tel_sto_sel,
    .brake_release_req, .brake_current_fb, .ctrl_heartbeat, .pulse_en_ctrl, .pulse_en_pwr,
    .quick_stop_ramp_command, .brake_high_switch, .brake_low_switch,
    .stop_notice_control_side, .stop_notice_power_side);
  dssb_partner #(.MON_CYCLES(M)) far (.pclk, .presetn, .brake_high_switch, .brake_low_switch,
    .hb_stop, .fb_stuck, .brake_current_fb, .ctrl_heartbeat);
  // ====
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state limit here; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r & mask, exp);
  endtask
  task automatic wait_bit(input int i, input logic v, input int lim);
    n = 0;
    while (outs[i] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // low selects, high deselects
  task automatic sel(input logic c, input logic p);
    @(posedge pclk);
    sel_ctrl_n <= c;
    sel_pwr_n <= p;
  endtask
  task automatic tel(input logic s);
    @(posedge pclk);
    tel_valid <= 1'b1;
    tel_sto_sel <= s;
    @(posedge pclk);
    tel_valid <= 1'b0;
  endtask
  task automatic clear_faults;
    // let two ticks pass so the cause is gone before the clear, else it sets again
    repeat (2 * M) @(posedge pclk);
    apb(1'b1, OFS_FAULT, 32'h7);
    rd(OFS_FAULT, 32'h7, 32'h0);
    wait_bit(0, 1'b1, 5 * M);
  endtask
  function automatic logic [31:0] en_word(input logic [3:0] c, input logic [3:0] p, input logic [1:0] m);
    return (32'(c) << EN_SAFE_C_LSB) | (32'(p) << EN_SAFE_P_LSB) | (32'h1 << EN_BRK_C) |
      (32'h1 << EN_BRK_P) | (32'(m) << EN_MODE_LSB);
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    complete_run();
  end
  // ====
  // tests
  initial begin
    repeat (12) @(posedge pclk);
    chk({pulse_en_ctrl, pulse_en_pwr, brake_high_switch, brake_low_switch}, 32'h0);
    presetn <= 1'b1;
    rd(OFS_DLY_C, 32'hffffffff, {16'h0, RST_DLY});
    rd(OFS_DLY_P, 32'hffffffff, {16'h0, RST_DLY});
    rd(OFS_FILT, 32'hffffffff, {16'h0, RST_FILT});
    rd(OFS_TOL, 32'hffffffff, {16'h0, RST_TOL});
    rd(OFS_EN, 32'hffffffff, {16'h0, RST_EN});
    rd(8'h1c, 32'hffffffff, 32'h0);
    chk(e, 32'h1);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFS_EN, en_word(4'h1, 4'h1, m[1:0]));
      rd(OFS_STAT, 32'h0c00, {20'h0, 1'b1, (m == 0 || m == 3), 10'h0});
    end
    apb(1'b1, OFS_EN, en_word(4'h1, 4'h2, 2'h1));
    rd(OFS_STAT, 32'h0800, 32'h0);
    apb(1'b1, OFS_EN, en_word(4'h1, 4'h1, 2'h1));
    $display("test enables done");
    brake_release_req <= 1'b1;
    wait_bit(3, 1'b1, 5 * M);
    chk({brake_high_switch, brake_low_switch}, 32'h3);
    sel(1'b0, 1'b0);
    wait_bit(0, 1'b0, 5 * M);
    chk(n < 5 * M, 32'h1);
    chk(quick_stop_ramp_command, 32'h0);
    wait_bit(3, 1'b0, M);
    chk({brake_high_switch, brake_low_switch, pulse_en_pwr}, 32'h0);
    sel(1'b1, 1'b1);
    wait_bit(0, 1'b1, 5 * M);
    chk(pulse_en_ctrl, 32'h1);
    $display("test immediate stop done");
    // delay kept below tolerance plus cross-check
    apb(1'b1, OFS_DLY_C, D);
    apb(1'b1, OFS_DLY_P, D);
    sel(1'b0, 1'b0);
    wait_bit(2, 1'b1, 5 * M);
    chk({quick_stop_ramp_command, pulse_en_ctrl}, 32'h3);
    chk({stop_notice_control_side, stop_notice_power_side}, 32'h3);
    wait_bit(0, 1'b0, (D + 2) * M);
    chk(n >= D * M - 1 && n <= D * M + M + 1, 32'h1);
    sel(1'b1, 1'b1);
    wait_bit(0, 1'b1, 5 * M);
    $display("test timed stop done");
    sel(1'b0, 1'b0);
    wait_bit(2, 1'b1, 5 * M);
    repeat (M) @(posedge pclk);
    sel(1'b1, 1'b1);
    wait_bit(0, 1'b0, (D + 2) * M);
    chk(n < (D + 2) * M, 32'h1);
    wait_bit(0, 1'b1, 4 * M);
    chk(pulse_en_ctrl, 32'h1);
    $display("test withdrawn stop done");
    apb(1'b1, OFS_FILT, 32'h0202);
    sel(1'b0, 1'b0);
    repeat (M - 2) @(posedge pclk);
    sel(1'b1, 1'b1);
    wait_bit(2, 1'b1, 6 * M);
    chk(n, 6 * M);
    apb(1'b1, OFS_FILT, 32'h0);
    apb(1'b1, OFS_DLY_C, 32'h0);
    apb(1'b1, OFS_DLY_P, 32'h0);
    $display("test debounce done");
    sel(1'b0, 1'b1);
    wait_bit(1, 1'b0, 10 * M);
    chk(n < 10 * M, 32'h1);
    rd(OFS_FAULT, 32'h1, 32'h1);
    chk({brake_high_switch, brake_low_switch}, 32'h0);
    sel(1'b1, 1'b1);
    clear_faults();
    $display("test cross check done");
    wait_bit(3, 1'b1, 5 * M);
    @(posedge pclk);
    fb_stuck <= 1'b1;
    repeat (6 * M) @(posedge pclk);
    rd(OFS_FAULT, 32'h2, 32'h0);
    sel(1'b0, 1'b0);
    repeat (5 * M) @(posedge pclk);
    rd(OFS_FAULT, 32'h2, 32'h2);
    fb_stuck <= 1'b0;
    sel(1'b1, 1'b1);
    clear_faults();
    $display("test brake diagnosis done");
    wait_bit(3, 1'b1, 5 * M);
    @(posedge pclk);
    hb_stop <= 1'b1;
    wait_bit(3, 1'b0, 12 * M);
    chk(n < 12 * M, 32'h1);
    rd(OFS_FAULT, 32'h4, 32'h4);
    hb_stop <= 1'b0;
    clear_faults();
    $display("test heartbeat done");
    tel(1'b1);
    wait_bit(0, 1'b0, 8 * M);
    chk(n >= 3 * M && n < 8 * M, 32'h1);
    tel(1'b0);
    wait_bit(0, 1'b1, 8 * M);
    chk(pulse_en_ctrl, 32'h1);
    $display("test telegram done");
    complete_run();
  end
endmodule
